// >>> tb_temperature_sensor_i2c_readout.sv
// Self-checking bench: conversion timing, data format, alarms, modes
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_temperature_sensor_i2c_readout;
    import tsr_pkg::*;
    localparam int FAST = 20;
    localparam int CONV = 50;
    localparam int SPSP = 100;
    logic        sys_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic [1:0]  strap     = 2'h0;
    logic [15:0] raw       = 16'h5000;
    wire         scl, pull, sda_oe, crit_oe, lim_oe;
    wire         sda_line  = !(pull || sda_oe);
    int          n_fail = 0, checks_done = 0, cyc = 0, n;
    logic [15:0] q;
    logic        ok;
    logic [6:0]  dev;
    tsr_top #(.CONV_CYCLES(CONV), .FAST_CYCLES(FAST), .SPS_CONV_CYCLES(30), .SPS_PER_CYCLES(SPSP)) u_tsr_top (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .temp_raw_i(raw), .scl_i(scl), .sda_i(sda_line),
        .sda_o(), .sda_oe_o(sda_oe), .addr_select_low_i(strap[0]), .addr_select_high_i(strap[1]),
        .critical_alarm_out_o(), .critical_alarm_out_oe_o(crit_oe), .limit_alarm_o(),
        .limit_alarm_oe_o(lim_oe));
    tsr_i2c_master u_tsr_i2c_master (.clk_i(sys_clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(pull));
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_lim(input logic lvl, output int k);
        k = 0;
        while (lim_oe !== lvl && k < 400) begin
            idle(1);
            k++;
        end
    endtask
    function automatic logic over(input logic [15:0] v, input logic [15:0] lim);
        return $signed(v) > $signed(lim);
    endfunction
    task automatic summarize();
        $display("Counts: %0d checks, %0d failed", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(29579));
        idle(8);
        resetn_i = 1'b1;
        wait_lim(1'b1, n);
        `CHK("fast conv", 1'b1, n >= FAST && n <= FAST + 3)
        `CHK("crit default", 1'b1, crit_oe)
        raw = 16'h1000;
        wait_lim(1'b0, n);
        `CHK("conv period", CONV, n)
        $display("Test timing done");
        for (int i = 0; i < 4; i++) begin
            strap = 2'(i);
            idle(4);
            u_tsr_i2c_master.probe({BUS_ADDR_TOP, 2'(i)}, ok);
            `CHK("addr ack", 1'b1, ok)
            u_tsr_i2c_master.probe({BUS_ADDR_TOP, 2'(i + 1)}, ok);
            `CHK("addr nack", 1'b0, ok)
        end
        strap = 2'($urandom);
        dev = {BUS_ADDR_TOP, strap};
        raw = {4'h1, 12'($urandom)};
        idle(2 * CONV);
        u_tsr_i2c_master.rd(dev, REG_TEMP_HI, q);
        `CHK("temp 13 bit", {raw[15:3], 3'h0}, q)
        u_tsr_i2c_master.rd(dev, 8'h0c, q);
        `CHK("unmapped", 16'h0000, q)
        u_tsr_i2c_master.wr(dev, REG_MEAS_CFG, 8'h80);
        raw = {4'h1, 12'($urandom)};
        idle(2 * CONV);
        u_tsr_i2c_master.rd(dev, REG_TEMP_HI, q);
        `CHK("temp 16 bit", raw, q)
        u_tsr_i2c_master.rd(dev, REG_MEAS_CFG, q);
        `CHK("cfg fine", 8'h80, q[15:8])
        $display("Test format done");
        for (int k = 0; k < 8; k++) begin
            raw = 16'($urandom) & 16'hfff8;
            if (k == 0) raw = CRIT_RST;
            if (k == 1) raw = HIGH_RST;
            idle(2 * CONV + 4);
            `CHK("crit cmp", over(raw, CRIT_RST), crit_oe)
            `CHK("lim cmp", over(raw, HIGH_RST), lim_oe)
        end
        raw = 16'h1000;
        u_tsr_i2c_master.rd(dev, REG_STATUS, q);
        u_tsr_i2c_master.wr(dev, REG_MEAS_CFG, 8'h88);
        idle(2 * CONV);
        raw = 16'h3000;
        idle(2 * CONV);
        `CHK("int set", 1'b1, lim_oe)
        raw = 16'h1000;
        idle(2 * CONV);
        `CHK("int latched", 1'b1, lim_oe)
        u_tsr_i2c_master.rd(dev, REG_STATUS, q);
        `CHK("status limit", 1'b1, q[8 + STS_HIGH_BIT])
        `CHK("int cleared", 1'b0, lim_oe)
        $display("Test alarms done");
        u_tsr_i2c_master.wr(dev, REG_MEAS_CFG, 8'h60);
        raw = 16'h0a10;
        idle(3 * CONV);
        u_tsr_i2c_master.rd(dev, REG_TEMP_HI, q);
        `CHK("shutdown hold", 16'h1000, q)
        u_tsr_i2c_master.wr(dev, REG_MEAS_CFG, 8'h20);
        idle(CONV + 10);
        u_tsr_i2c_master.rd(dev, REG_TEMP_HI, q);
        `CHK("one shot", 16'h0a10, q)
        u_tsr_i2c_master.rd(dev, REG_MEAS_CFG, q);
        `CHK("one shot end", {1'b0, MODE_SHDN, 5'h00}, q[15:8])
        u_tsr_i2c_master.wr(dev, REG_MEAS_CFG, 8'h40);
        raw = 16'h3000;
        wait_lim(1'b1, n);
        raw = 16'h1000;
        wait_lim(1'b0, n);
        `CHK("sample period", SPSP, n)
        $display("Test modes done");
        summarize();
    end
endmodule
`default_nettype wire

// >>> tsr_i2c_master.sv
// Behavioural two-wire bus master for the sensor's serial port
`timescale 1ns/1ns
`default_nettype none
module tsr_i2c_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output var logic  scl_o,
    output var logic  sda_pull_o
);
    // Clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Start when b is set, stop otherwise
    task automatic cond(input logic a, input logic b);
        tick(1);
        sda_pull_o = a;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        sda_pull_o = b;
        tick(4);
        scl_o = !b;
    endtask
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_pull_o = !b;
        tick(3);
        scl_o = 1'b1;
        tick(4);
        r = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], a);
            q[i] = a;
        end
        bit_io(ack_bit, a);
        ok = !a;
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        cond(1'b0, 1'b1);
        xfer({dev, 1'b0}, 1'b1, q, ok);
        xfer(ptr, 1'b1, q, ok);
        xfer(d, 1'b1, q, ok);
        cond(1'b1, 1'b0);
    endtask
    task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, output logic [15:0] r);
        logic [7:0] q;
        logic ok;
        cond(1'b0, 1'b1);
        xfer({dev, 1'b0}, 1'b1, q, ok);
        xfer(ptr, 1'b1, q, ok);
        cond(1'b0, 1'b1);
        xfer({dev, 1'b1}, 1'b1, q, ok);
        xfer(8'hff, 1'b0, r[15:8], ok);
        xfer(8'hff, 1'b1, r[7:0], ok);
        cond(1'b1, 1'b0);
    endtask
    task automatic probe(input logic [6:0] dev, output logic ok);
        logic [7:0] q;
        cond(1'b0, 1'b1);
        xfer({dev, 1'b0}, 1'b1, q, ok);
        cond(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> tsr_i2c_slave.sv
// Two-wire serial slave with register pointer and auto-increment
`timescale 1ns/1ns
`default_nettype none
module tsr_i2c_slave
    import tsr_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic [6:0] dev_addr_i,
    input  wire logic [7:0] rd_data_i,
    output logic            sda_oe_o,
    output logic [7:0]      ptr_o,
    output logic            wr_o,
    output logic [7:0]      wr_data_o,
    output logic            rd_o
);
    tsr_bus_t   st_r;
    logic       scl_q_r;
    logic       sda_q_r;
    logic [3:0] bitcnt_r;
    logic [7:0] sh_r;
    logic       rw_r;
    logic       first_r;
    logic       nack_r;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;

    assign rise  = scl_i & ~scl_q_r;
    assign fall  = ~scl_i & scl_q_r;
    assign start = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r      <= BS_IDLE;
            bitcnt_r  <= 4'h0;
            sh_r      <= 8'h00;
            rw_r      <= 1'b0;
            first_r   <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe_o  <= 1'b0;
            ptr_o     <= 8'h00;
            wr_o      <= 1'b0;
            wr_data_o <= 8'h00;
            rd_o      <= 1'b0;
        end else begin
            wr_o <= 1'b0;
            rd_o <= 1'b0;
            if (start) begin
                st_r     <= BS_ADDR;
                bitcnt_r <= 4'h0;
                first_r  <= 1'b1;
                sda_oe_o <= 1'b0;
            end else if (stop) begin
                st_r     <= BS_IDLE;
                sda_oe_o <= 1'b0;
            end else begin
                case (st_r)
                    BS_ADDR, BS_WDATA: begin
                        if (rise) begin
                            sh_r     <= {sh_r[6:0], sda_i};
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (fall && bitcnt_r == 4'h8) begin
                            if (st_r == BS_ADDR) begin
                                if (sh_r[7:1] == dev_addr_i) begin
                                    st_r     <= BS_ACKA;
                                    rw_r     <= sh_r[0];
                                    sda_oe_o <= 1'b1;
                                end else begin
                                    st_r <= BS_IDLE;
                                end
                            end else begin
                                st_r     <= BS_ACKW;
                                sda_oe_o <= 1'b1;
                                if (first_r) begin
                                    ptr_o   <= sh_r;
                                    first_r <= 1'b0;
                                end else begin
                                    wr_o      <= 1'b1;
                                    wr_data_o <= sh_r;
                                end
                            end
                        end
                    end
                    BS_ACKW: begin
                        if (fall) begin
                            sda_oe_o <= 1'b0;
                            bitcnt_r <= 4'h0;
                            st_r     <= BS_WDATA;
                            if (wr_o == 1'b0 && first_r == 1'b0 && st_r == BS_ACKW && rw_r == 1'b0) begin
                                ptr_o <= ptr_o;
                            end
                        end else if (wr_o) begin
                            ptr_o <= ptr_o + 8'h01;
                        end
                    end
                    BS_ACKA, BS_RACK: begin
                        if (rise) begin
                            nack_r <= (st_r == BS_RACK) & sda_i;
                        end else if (fall) begin
                            bitcnt_r <= 4'h0;
                            if (!rw_r) begin
                                sda_oe_o <= 1'b0;
                                st_r     <= BS_WDATA;
                            end else if (nack_r) begin
                                sda_oe_o <= 1'b0;
                                st_r     <= BS_IDLE;
                            end else begin
                                // Data sampled at load; later changes wait for the next byte
                                sh_r     <= rd_data_i;
                                rd_o     <= 1'b1;
                                sda_oe_o <= ~rd_data_i[7];
                                st_r     <= BS_RDATA;
                            end
                        end
                    end
                    BS_RDATA: begin
                        if (rise) begin
                            bitcnt_r <= bitcnt_r + 4'h1;
                        end else if (fall) begin
                            if (bitcnt_r == 4'h8) begin
                                sda_oe_o <= 1'b0;
                                ptr_o    <= ptr_o + 8'h01;
                                st_r     <= BS_RACK;
                            end else begin
                                sh_r     <= {sh_r[6:0], 1'b0};
                                sda_oe_o <= ~sh_r[6];
                            end
                        end
                    end
                    default: begin
                        st_r     <= BS_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> tsr_pkg.sv
// Package: register map, field layout, reset values and timing of the sensor readout
package tsr_pkg;
    // -----------------------------------------------------------------
    // Register pointer values
    // -----------------------------------------------------------------
    localparam logic [7:0] REG_TEMP_HI    = 8'h00;
    localparam logic [7:0] REG_TEMP_LO    = 8'h01;
    localparam logic [7:0] REG_STATUS     = 8'h02;
    localparam logic [7:0] REG_MEAS_CFG   = 8'h03;
    localparam logic [7:0] REG_HIGH_HI    = 8'h04;
    localparam logic [7:0] REG_HIGH_LO    = 8'h05;
    localparam logic [7:0] REG_CRIT_HI    = 8'h08;
    localparam logic [7:0] REG_CRIT_LO    = 8'h09;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int CFG_RES_BIT      = 7;
    localparam int CFG_MODE_HI      = 6;
    localparam int CFG_MODE_LO      = 5;
    localparam int CFG_INTMODE_BIT  = 3;
    localparam int STS_NRDY_BIT     = 7;
    localparam int STS_CRIT_BIT     = 6;
    localparam int STS_HIGH_BIT     = 4;
    localparam int LOW_RES_DROP     = 3;

    // Operating modes in the configuration mode field
    localparam logic [1:0] MODE_CONT  = 2'h0;
    localparam logic [1:0] MODE_ONE   = 2'h1;
    localparam logic [1:0] MODE_SPS   = 2'h2;
    localparam logic [1:0] MODE_SHDN  = 2'h3;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0]  MEAS_CFG_RST = 8'h00;
    localparam logic [15:0] CRIT_RST     = 16'h4980;
    localparam logic [15:0] HIGH_RST     = 16'h2000;
    localparam logic [4:0]  BUS_ADDR_TOP = 5'h12;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ       = 50000000;
    localparam int CONV_MS      = 240;
    localparam int FAST_MS      = 6;
    localparam int SPS_CONV_MS  = 60;
    localparam int SPS_PERIOD_MS = 1000;
    localparam int CONV_CYC     = CLK_HZ / 1000 * CONV_MS;
    localparam int FAST_CYC     = CLK_HZ / 1000 * FAST_MS;
    localparam int SPS_CONV_CYC = CLK_HZ / 1000 * SPS_CONV_MS;
    localparam int SPS_PER_CYC  = CLK_HZ / 1000 * SPS_PERIOD_MS;

    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_CONV = 3'b010,
        CV_WAIT = 3'b100
    } tsr_conv_t;

    typedef enum logic [6:0] {
        BS_IDLE  = 7'b0000001,
        BS_ADDR  = 7'b0000010,
        BS_ACKA  = 7'b0000100,
        BS_WDATA = 7'b0001000,
        BS_ACKW  = 7'b0010000,
        BS_RDATA = 7'b0100000,
        BS_RACK  = 7'b1000000
    } tsr_bus_t;
endpackage

// >>> tsr_props.sv
// Checker: port-level relations of the sensor readout
`timescale 1ns/1ns
`default_nettype none
module tsr_props
    import tsr_pkg::*;
#(
    parameter int FAST_CYCLES = 20
) (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic [15:0] temp_raw_i,
    input wire logic        scl_i,
    input wire logic        sda_o,
    input wire logic        sda_oe_o,
    input wire logic        critical_alarm_out_o,
    input wire logic        critical_alarm_out_oe_o,
    input wire logic        limit_alarm_o,
    input wire logic        limit_alarm_oe_o
);
    logic [7:0] up_cnt_r;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            up_cnt_r <= 8'h00;
        else if (up_cnt_r != 8'hff)
            up_cnt_r <= up_cnt_r + 8'h01;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    // Capture edge is known only to a cycle, so any of three samples may be the cause
    sequence s_cause(lim);
        $signed($past(temp_raw_i, 1)) > $signed(lim) || $signed($past(temp_raw_i, 2)) > $signed(lim)
            || $signed($past(temp_raw_i, 3)) > $signed(lim);
    endsequence
    chk_sda_value: assert property (sda_o == 1'b0) else $error("sda data not low");
    chk_crit_value: assert property (critical_alarm_out_o == 1'b0) else $error("crit data not low");
    chk_lim_value: assert property (limit_alarm_o == 1'b0) else $error("limit data not low");
    chk_fast_quiet: assert property (int'(up_cnt_r) < FAST_CYCLES |->
        !critical_alarm_out_oe_o && !limit_alarm_oe_o) else $error("alarm before first result");
    chk_crit_cause: assert property ($rose(critical_alarm_out_oe_o) |-> s_cause(CRIT_RST))
        else $error("crit alarm without cause");
    chk_lim_cause: assert property ($rose(limit_alarm_oe_o) |-> s_cause(HIGH_RST))
        else $error("limit alarm without cause");
    chk_lim_hold: assert property ($rose(limit_alarm_oe_o) |-> limit_alarm_oe_o[*8])
        else $error("limit alarm glitch");
    chk_sda_on_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
        else $error("sda moved while clock high");
    chk_ack_hold: assert property ($rose(sda_oe_o) |-> sda_oe_o[*5]) else $error("sda pull too short");
endmodule

bind tsr_top tsr_props #(.FAST_CYCLES(FAST_CYCLES)) u_tsr_props (
    .sys_clk_i, .resetn_i, .temp_raw_i, .scl_i, .sda_o, .sda_oe_o, .critical_alarm_out_o,
    .critical_alarm_out_oe_o, .limit_alarm_o, .limit_alarm_oe_o);
`default_nettype wire

// >>> tsr_top.sv
// Temperature sensor digital readout: conversion timing, limits, alarms, register file
//
// Functional notes
// - Power-up resolution is thirteen bits
// - Config bit 7 selects sixteen-bit resolution
// - Thirteen-bit result: sign plus twelve bits
// - Sixteen-bit result: sign plus fifteen bits
// - Continuous and one-shot conversions take 240 ms
// - First conversion after power-up takes 6 ms
// - One-per-second mode: 60 ms conversion each second
// - Critical alarm above limit, default 147 C
// - Limit alarm above programmable limit
// - Both alarms: comparator or interrupt mode
// - Two strap pins choose four bus addresses
// - Shutdown stops all new conversions
`timescale 1ns/1ns
`default_nettype none
module tsr_top
    import tsr_pkg::*;
#(
    parameter int CONV_CYCLES     = CONV_CYC,
    parameter int FAST_CYCLES     = FAST_CYC,
    parameter int SPS_CONV_CYCLES = SPS_CONV_CYC,
    parameter int SPS_PER_CYCLES  = SPS_PER_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [15:0] temp_raw_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_o,
    input  wire logic        addr_select_low_i,
    input  wire logic        addr_select_high_i,
    output logic             critical_alarm_out_o,
    output logic             critical_alarm_out_oe_o,
    output logic             limit_alarm_o,
    output logic             limit_alarm_oe_o
);
    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= 4'hf;
            sync2_r <= 4'hf;
        end else begin
            sync1_r <= {addr_select_high_i, addr_select_low_i, sda_i, scl_i};
            sync2_r <= sync1_r;
        end
    end

    // -----------------------------------------------------------------
    // Serial slave
    // -----------------------------------------------------------------
    logic [7:0] ptr;
    logic       wr;
    logic [7:0] wr_data;
    logic       rd;
    logic [7:0] rd_data;
    logic [6:0] dev_addr_r;

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dev_addr_r <= 7'h00;
        end else begin
            dev_addr_r <= {BUS_ADDR_TOP, sync2_r[3], sync2_r[2]};
        end
    end

    tsr_i2c_slave u_slave (
        .sys_clk_i  (sys_clk_i),
        .resetn_i   (resetn_i),
        .scl_i      (sync2_r[0]),
        .sda_i      (sync2_r[1]),
        .dev_addr_i (dev_addr_r),
        .rd_data_i  (rd_data),
        .sda_oe_o   (sda_oe_o),
        .ptr_o      (ptr),
        .wr_o       (wr),
        .wr_data_o  (wr_data),
        .rd_o       (rd)
    );

    // Open-drain pins only ever pull low
    assign sda_o                = 1'b0;
    assign critical_alarm_out_o = 1'b0;
    assign limit_alarm_o        = 1'b0;

    function automatic logic hit(input logic strobe, input logic [7:0] p, input logic [7:0] off);
        hit = strobe && (p == off);
    endfunction

    // -----------------------------------------------------------------
    // Writable registers
    // -----------------------------------------------------------------
    logic [7:0]  meas_config_r;
    logic [15:0] crit_limit_r;
    logic [15:0] high_limit_r;
    logic        oneshot_done;
    logic        cfg_wr;

    assign cfg_wr = hit(wr, ptr, REG_MEAS_CFG);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meas_config_r <= MEAS_CFG_RST;
        end else if (cfg_wr) begin
            meas_config_r <= wr_data;
        end else if (oneshot_done) begin
            meas_config_r[CFG_MODE_HI:CFG_MODE_LO] <= MODE_SHDN;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crit_limit_r <= CRIT_RST;
            high_limit_r <= HIGH_RST;
        end else begin
            if (hit(wr, ptr, REG_CRIT_HI)) crit_limit_r[15:8] <= wr_data;
            if (hit(wr, ptr, REG_CRIT_LO)) crit_limit_r[7:0] <= wr_data;
            if (hit(wr, ptr, REG_HIGH_HI)) high_limit_r[15:8] <= wr_data;
            if (hit(wr, ptr, REG_HIGH_LO)) high_limit_r[7:0] <= wr_data;
        end
    end

    // -----------------------------------------------------------------
    // Conversion sequencer
    // -----------------------------------------------------------------
    tsr_conv_t   cv_r;
    logic [25:0] cnt_r;
    logic        first_conv_r;
    logic [1:0]  mode;
    logic [25:0] conv_len;
    logic        conv_end;

    assign mode = meas_config_r[CFG_MODE_HI:CFG_MODE_LO];

    assign conv_len = first_conv_r ? 26'(FAST_CYCLES) :
                      (mode == MODE_SPS) ? 26'(SPS_CONV_CYCLES) : 26'(CONV_CYCLES);
    assign conv_end     = (cv_r == CV_CONV) && (cnt_r == conv_len - 26'h1) && !cfg_wr;
    assign oneshot_done = conv_end && (mode == MODE_ONE);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cv_r         <= CV_CONV;
            cnt_r        <= 26'h0;
            first_conv_r <= 1'b1;
        end else if (cfg_wr) begin
            // Any config write restarts timing so a mode change never inherits a stale count
            cnt_r <= 26'h0;
            cv_r  <= (wr_data[CFG_MODE_HI:CFG_MODE_LO] == MODE_SHDN) ? CV_IDLE : CV_CONV;
        end else begin
            case (cv_r)
                CV_CONV: begin
                    cnt_r <= cnt_r + 26'h1;
                    if (conv_end) begin
                        first_conv_r <= 1'b0;
                        if (mode == MODE_CONT) begin
                            cnt_r <= 26'h0;
                        end else if (mode == MODE_SPS) begin
                            cv_r <= CV_WAIT;
                        end else begin
                            cv_r <= CV_IDLE;
                        end
                    end
                end
                CV_WAIT: begin
                    if (cnt_r >= 26'(SPS_PER_CYCLES) - 26'h1) begin
                        cnt_r <= 26'h0;
                        cv_r  <= CV_CONV;
                    end else begin
                        cnt_r <= cnt_r + 26'h1;
                    end
                end
                CV_IDLE: begin
                    cnt_r <= 26'h0;
                end
                default: begin
                    cv_r  <= CV_IDLE;
                    cnt_r <= 26'h0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Result, status and alarms
    // -----------------------------------------------------------------
    logic [15:0] temp_r;
    logic        nrdy_r;
    logic        crit_flag_r;
    logic        high_flag_r;
    logic        crit_cmp_r;
    logic        high_cmp_r;
    logic [15:0] sample;
    logic        crit_over;
    logic        high_over;
    logic        sts_rd;

    assign sample    = meas_config_r[CFG_RES_BIT] ? temp_raw_i :
                       {temp_raw_i[15:LOW_RES_DROP], {LOW_RES_DROP{1'b0}}};
    assign crit_over = $signed(sample) > $signed(crit_limit_r);
    assign high_over = $signed(sample) > $signed(high_limit_r);
    assign sts_rd    = hit(rd, ptr, REG_STATUS);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            temp_r     <= 16'h0000;
            crit_cmp_r <= 1'b0;
            high_cmp_r <= 1'b0;
        end else if (conv_end) begin
            temp_r     <= sample;
            crit_cmp_r <= crit_over;
            high_cmp_r <= high_over;
        end
    end

    // New result beats a same-cycle read
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nrdy_r <= 1'b1;
        end else if (conv_end) begin
            nrdy_r <= 1'b0;
        end else if (hit(rd, ptr, REG_TEMP_LO)) begin
            nrdy_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crit_flag_r <= 1'b0;
            high_flag_r <= 1'b0;
        end else begin
            if (conv_end && crit_over && !crit_cmp_r) begin
                crit_flag_r <= 1'b1;
            end else if (sts_rd) begin
                crit_flag_r <= 1'b0;
            end
            if (conv_end && high_over && !high_cmp_r) begin
                high_flag_r <= 1'b1;
            end else if (sts_rd) begin
                high_flag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            critical_alarm_out_oe_o <= 1'b0;
            limit_alarm_oe_o        <= 1'b0;
        end else begin
            critical_alarm_out_oe_o <= meas_config_r[CFG_INTMODE_BIT] ? crit_flag_r : crit_cmp_r;
            limit_alarm_oe_o        <= meas_config_r[CFG_INTMODE_BIT] ? high_flag_r : high_cmp_r;
        end
    end

    // -----------------------------------------------------------------
    // Read mux
    // -----------------------------------------------------------------
    always_comb begin
        case (ptr)
            REG_TEMP_HI:  rd_data = temp_r[15:8];
            REG_TEMP_LO:  rd_data = temp_r[7:0];
            REG_STATUS:   rd_data = {nrdy_r, crit_flag_r, 1'b0, high_flag_r, 4'h0};
            REG_MEAS_CFG: rd_data = meas_config_r;
            REG_HIGH_HI:  rd_data = high_limit_r[15:8];
            REG_HIGH_LO:  rd_data = high_limit_r[7:0];
            REG_CRIT_HI:  rd_data = crit_limit_r[15:8];
            REG_CRIT_LO:  rd_data = crit_limit_r[7:0];
            default:      rd_data = 8'h00;
        endcase
    end
endmodule
`default_nettype wire
